// ===== src/tef_pkg.sv
// package: constants and carriers for the timer channel event flag block
package tef_pkg;

    // =====================================================================
    // geometry
    localparam int unsigned NUM_CH      = 5;
    localparam int unsigned DMA_CH_LAST = 3;

    // =====================================================================
    // register select codes on the 8-bit register port
    localparam logic [3:0] SEL_STATUS_CH0 = 4'h0;
    localparam logic [3:0] SEL_STATUS_CH4 = 4'h4;
    localparam logic [3:0] SEL_ENABLE_CH0 = 4'h8;
    localparam logic [3:0] SEL_ENABLE_CH4 = 4'hC;

    // =====================================================================
    // field layout and reset values
    localparam int unsigned BIT_WRAP  = 2;
    localparam int unsigned BIT_REG_B = 1;
    localparam int unsigned BIT_REG_A = 0;
    localparam logic [7:0] STATUS_RESET = 8'hF8;
    localparam logic [7:0] ENABLE_RESET = 8'hF8;
    localparam logic [7:0] RSVD_MASK    = 8'hF8;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic wrap;
        logic reg_b;
        logic reg_a;
    } tef_flags_s;

    typedef struct packed {
        logic       cyc;
        logic       wr;
        logic [3:0] sel;
        logic [7:0] wdata;
    } tef_bus_req_s;

    typedef struct packed {
        logic count_up_wrap;
        logic count_down_wrap;
        logic reg_b_compare;
        logic reg_b_capture;
        logic reg_a_compare;
        logic reg_a_capture;
        logic reg_b_is_capture;
        logic reg_a_is_capture;
    } tef_event_s;

endpackage

// ===== src/tef_top.sv
// module: per-channel event status and interrupt enable registers of the timer
`timescale 1ns/100ps
module tef_top #(
    parameter int unsigned NCH = tef_pkg::NUM_CH
) (
    // clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      standby_i,
    // register port
    input  wire tef_pkg::tef_bus_req_s     bus_req_i,
    output logic [7:0]                     bus_rdata_o,
    // event strobes and mode from the counter logic
    input  wire tef_pkg::tef_event_s       event_i [NCH],
    input  wire logic                      phase_count_mode_flag_i,
    input  wire logic                      combo_mode_hi_i,
    input  wire logic                      combo_mode_lo_i,
    // dma transfer started by register A interrupt
    input  wire logic [NCH-1:0]            dma_ack_a_i,
    // interrupt requests
    output logic [NCH-1:0]                 wrap_irq_o,
    output logic [NCH-1:0]                 reg_b_irq_o,
    output logic [NCH-1:0]                 reg_a_irq_o
);

    // =====================================================================
    // state
    typedef struct packed {
        tef_pkg::tef_flags_s [NCH-1:0] flag;
        tef_pkg::tef_flags_s [NCH-1:0] armed;
        tef_pkg::tef_flags_s [NCH-1:0] en;
        logic [7:0]                    rdata;
    } tef_state_s;

    tef_state_s state_reg;
    tef_state_s state_next;
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    // =====================================================================
    // reset release
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // =====================================================================
    // helpers
    function automatic logic [7:0] pack_bits(input tef_pkg::tef_flags_s f);
        pack_bits = tef_pkg::RSVD_MASK | {5'h00, f.wrap, f.reg_b, f.reg_a};
    endfunction

    function automatic logic down_wrap_legal(input int unsigned ch, input logic pcm,
                                             input logic chi, input logic clo);
        down_wrap_legal = ((ch == 2) && pcm) || ((ch >= 3) && chi && !clo);
    endfunction

    function automatic logic bus_hit(input tef_pkg::tef_bus_req_s req, input logic [3:0] sel,
                                     input logic is_wr);
        bus_hit = req.cyc && (req.wr == is_wr) && (req.sel == sel);
    endfunction

    // =====================================================================
    // next state
    always_comb begin
        logic       wr_hit;
        logic       rd_hit;
        logic [7:0] wd;
        logic       set_w;
        logic       set_b;
        logic       set_a;
        logic       clr_w;
        logic       clr_b;
        logic       clr_a;
        wr_hit     = 1'b0;
        rd_hit     = 1'b0;
        wd         = bus_req_i.wdata;
        set_w      = 1'b0;
        set_b      = 1'b0;
        set_a      = 1'b0;
        clr_w      = 1'b0;
        clr_b      = 1'b0;
        clr_a      = 1'b0;
        state_next = state_reg;
        state_next.rdata = 8'h00;
        for (int unsigned c = 0; c < NCH; c++) begin
            // status register access
            wr_hit = bus_hit(bus_req_i, tef_pkg::SEL_STATUS_CH0 + 4'(c), 1'b1);
            rd_hit = bus_hit(bus_req_i, tef_pkg::SEL_STATUS_CH0 + 4'(c), 1'b0);
            if (rd_hit) begin
                state_next.rdata = pack_bits(state_reg.flag[c]);
                state_next.armed[c] = state_reg.flag[c];
            end
            clr_w = wr_hit && !wd[tef_pkg::BIT_WRAP] && state_reg.armed[c].wrap;
            clr_b = wr_hit && !wd[tef_pkg::BIT_REG_B] && state_reg.armed[c].reg_b;
            clr_a = wr_hit && !wd[tef_pkg::BIT_REG_A] && state_reg.armed[c].reg_a;
            if (c <= tef_pkg::DMA_CH_LAST) begin
                clr_a = clr_a || (dma_ack_a_i[c] && state_reg.flag[c].reg_a);
            end
            if (wr_hit) begin
                state_next.armed[c] = '0;
            end
            // event sources
            set_w = event_i[c].count_up_wrap
                || (event_i[c].count_down_wrap
                    && down_wrap_legal(c, phase_count_mode_flag_i, combo_mode_hi_i, combo_mode_lo_i));
            set_b = (event_i[c].reg_b_compare && !event_i[c].reg_b_is_capture)
                || (event_i[c].reg_b_capture && event_i[c].reg_b_is_capture);
            set_a = (event_i[c].reg_a_compare && !event_i[c].reg_a_is_capture)
                || (event_i[c].reg_a_capture && event_i[c].reg_a_is_capture);
            // set wins over clear
            state_next.flag[c].wrap  = set_w || (state_reg.flag[c].wrap && !clr_w);
            state_next.flag[c].reg_b = set_b || (state_reg.flag[c].reg_b && !clr_b);
            state_next.flag[c].reg_a = set_a || (state_reg.flag[c].reg_a && !clr_a);
            // enable register access
            wr_hit = bus_hit(bus_req_i, tef_pkg::SEL_ENABLE_CH0 + 4'(c), 1'b1);
            rd_hit = bus_hit(bus_req_i, tef_pkg::SEL_ENABLE_CH0 + 4'(c), 1'b0);
            if (wr_hit) begin
                state_next.en[c] = tef_pkg::tef_flags_s'(wd[2:0]);
            end
            if (rd_hit) begin
                state_next.rdata = pack_bits(state_reg.en[c]);
            end
        end
        if (standby_i) begin
            for (int unsigned c = 0; c < NCH; c++) begin
                state_next.flag[c]  = tef_pkg::tef_flags_s'(tef_pkg::STATUS_RESET[2:0]);
                state_next.armed[c] = '0;
                state_next.en[c]    = tef_pkg::tef_flags_s'(tef_pkg::ENABLE_RESET[2:0]);
            end
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int unsigned c = 0; c < NCH; c++) begin
                state_reg.flag[c]  <= tef_pkg::tef_flags_s'(tef_pkg::STATUS_RESET[2:0]);
                state_reg.armed[c] <= '0;
                state_reg.en[c]    <= tef_pkg::tef_flags_s'(tef_pkg::ENABLE_RESET[2:0]);
            end
            state_reg.rdata <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // =====================================================================
    // outputs
    assign bus_rdata_o = state_reg.rdata;
    always_comb begin
        for (int unsigned c = 0; c < NCH; c++) begin
            wrap_irq_o[c]  = state_reg.flag[c].wrap  && state_reg.en[c].wrap;
            reg_b_irq_o[c] = state_reg.flag[c].reg_b && state_reg.en[c].reg_b;
            reg_a_irq_o[c] = state_reg.flag[c].reg_a && state_reg.en[c].reg_a;
        end
    end

endmodule

// ===== tb/tef_dma_model.sv
// dma controller model answering register a requests after a set delay
`timescale 1ns/100ps
module tef_dma_model #(
    parameter int DLY = 2
) (
    input  wire logic       mclk_i,
    input  wire logic [4:0] irq_i,
    input  wire logic [4:0] arm_i,
    output logic      [4:0] ack_o
);
    int cnt [5] = '{default: 0};
    always @(negedge mclk_i) begin
        for (int c = 0; c < 5; c++) begin
            cnt[c] = (irq_i[c] && arm_i[c]) ? cnt[c] + 1 : 0;
            ack_o[c] <= (cnt[c] == DLY);
        end
    end
endmodule

// ===== tb/tef_flags_sva.sv
// assertion checker for the timer channel event flag block
`timescale 1ns/100ps
module tef_flags_sva #(
    parameter int unsigned NCH = 5
) (
    input wire logic                  mclk_i,
    input wire logic                  resetn_i,
    input wire logic                  standby_i,
    input wire tef_pkg::tef_bus_req_s bus_req_i,
    input wire logic [7:0]            bus_rdata_o,
    input wire tef_pkg::tef_event_s   event_i [NCH],
    input wire logic [NCH-1:0]        wrap_irq_o,
    input wire logic [NCH-1:0]        reg_b_irq_o,
    input wire logic [NCH-1:0]        reg_a_irq_o
);
    wire logic rd = bus_req_i.cyc && !bus_req_i.wr;
    wire logic wr = bus_req_i.cyc && bus_req_i.wr;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    sequence b0_set;
        event_i[0].reg_b_compare && !event_i[0].reg_b_is_capture && !standby_i;
    endsequence
    AST_RD_IDLE: assert property (!$past(rd) |-> bus_rdata_o == 8'h00)
        else $error("read data not idle");
    AST_RSVD_ONES: assert property ($past(rd && bus_req_i.sel[2:0] < 3'h5) |-> bus_rdata_o[7:3] == 5'h1F)
        else $error("reserved bits not one");
    AST_UNMAPPED: assert property ($past(rd && bus_req_i.sel[2:0] > 3'h4) |-> bus_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_WRAP_CAUSE: assert property ($rose(wrap_irq_o[0]) |-> $past(event_i[0].count_up_wrap || wr && bus_req_i.sel == 4'h8))
        else $error("wrap request without cause");
    AST_B_FALL: assert property ($fell(reg_b_irq_o[0]) |-> $past(standby_i || wr && bus_req_i.sel[2:0] == 3'h0))
        else $error("b request dropped without write");
    AST_A4_FALL: assert property ($fell(reg_a_irq_o[4]) |-> $past(standby_i || wr && bus_req_i.sel[2:0] == 3'h4))
        else $error("channel 4 a request dropped");
    AST_STANDBY: assert property (standby_i |=> (wrap_irq_o | reg_b_irq_o | reg_a_irq_o) == '0)
        else $error("request alive in standby");
    AST_SET_WINS: assert property (reg_b_irq_o[0] ##0 b0_set |=> reg_b_irq_o[0] || $past(wr && bus_req_i.sel == 4'h8))
        else $error("set lost to clear");
endmodule
bind tef_top tef_flags_sva #(.NCH(NCH)) sva (.mclk_i(mclk_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o), .event_i(event_i), .wrap_irq_o(wrap_irq_o),
    .reg_b_irq_o(reg_b_irq_o), .reg_a_irq_o(reg_a_irq_o));

// ===== tb/testbench.sv
// self-checking testbench for the timer channel event flag block
`timescale 1ns/100ps
module testbench;
    logic                  mclk_i = 1'b0;
    logic                  rstn_n = 1'b0;
    logic                  stby   = 1'b0;
    logic                  ph     = 1'b0;
    logic                  hi     = 1'b0;
    logic                  lo     = 1'b0;
    logic [4:0]            arm    = 5'h00;
    tef_pkg::tef_bus_req_s req    = '0;
    tef_pkg::tef_event_s   ev [5] = '{default: '0};
    logic [7:0]            rdata;
    logic [7:0]            r;
    logic [4:0]            wi, bi, ai, ack;
    int                    fails  = 0;
    int                    checks = 0;
    int                    n;
    initial forever #25 mclk_i = ~mclk_i;
    tef_top dut (.mclk_i(mclk_i), .resetn_i(rstn_n), .standby_i(stby), .bus_req_i(req), .bus_rdata_o(rdata),
        .event_i(ev), .phase_count_mode_flag_i(ph), .combo_mode_hi_i(hi), .combo_mode_lo_i(lo),
        .dma_ack_a_i(ack), .wrap_irq_o(wi), .reg_b_irq_o(bi), .reg_a_irq_o(ai));
    tef_dma_model #(.DLY(2)) dma (.mclk_i(mclk_i), .irq_i(ai), .arm_i(arm), .ack_o(ack));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task acc(input logic w, input logic [3:0] s, input logic [7:0] d);
        req = '{1'b1, w, s, d};
        @(negedge mclk_i);
        r = rdata;
        req.cyc = 1'b0;
        @(negedge mclk_i);
    endtask
    task pulse(input int c, input logic [7:0] e);
        ev[c] = e;
        @(negedge mclk_i);
        ev[c] = '0;
    endtask
    task wrap_up;
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task t_map;
        for (int s = 0; s < 16; s++) begin
            acc(1'b0, 4'(s), 8'h00);
            chk(r, (s % 8 < 5) ? 8'hF8 : 8'h00);
        end
        for (int c = 0; c < 5; c++) begin
            acc(1'b1, 4'(8 + c), 8'h07);
            acc(1'b0, 4'(8 + c), 8'h00);
            chk(r, 8'hFF);
        end
    endtask
    task automatic t_events;
        logic [7:0] e [10] = '{8'h80, 8'h40, 8'h20, 8'h22, 8'h12, 8'h10, 8'h08, 8'h09, 8'h05, 8'h04};
        logic [2:0] f [10] = '{3'h4, 3'h0, 3'h2, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
        for (int i = 0; i < 10; i++) begin
            pulse(0, e[i]);
            chk({5'h00, wi[0], bi[0], ai[0]}, {5'h00, f[i]});
            acc(1'b0, 4'h0, 8'h00);
            chk(r, {5'h1F, f[i]});
            acc(1'b1, 4'h0, 8'hF8);
        end
    endtask
    task automatic t_down;
        int         ch [5] = '{2, 2, 3, 4, 3};
        logic [3:0] m  [5] = '{4'hC, 4'h2, 4'hA, 4'hA, 4'h3};
        for (int i = 0; i < 5; i++) begin
            {ph, hi, lo} = m[i][2:0];
            pulse(ch[i], 8'h40);
            chk({7'h00, wi[ch[i]]}, {7'h00, m[i][3]});
            acc(1'b0, 4'(ch[i]), 8'h00);
            acc(1'b1, 4'(ch[i]), 8'hF8);
        end
    endtask
    task t_clear;
        pulse(0, 8'h20);
        acc(1'b1, 4'h0, 8'hF8);
        chk({7'h00, bi[0]}, 8'h01);
        acc(1'b0, 4'h0, 8'h00);
        acc(1'b1, 4'h0, 8'hFF);
        chk({7'h00, bi[0]}, 8'h01);
        acc(1'b0, 4'h0, 8'h00);
        fork
            pulse(0, 8'h20);
            acc(1'b1, 4'h0, 8'hF8);
        join
        chk({7'h00, bi[0]}, 8'h01);
        acc(1'b0, 4'h0, 8'h00);
        acc(1'b1, 4'h0, 8'hF8);
        chk({7'h00, bi[0]}, 8'h00);
    endtask
    task t_mask;
        pulse(3, 8'hA8);
        for (int b = 0; b < 3; b++) begin
            acc(1'b1, 4'hB, 8'h01 << b);
            chk({5'h00, wi[3], bi[3], ai[3]}, 8'h01 << b);
        end
        acc(1'b0, 4'h3, 8'h00);
        acc(1'b1, 4'h3, 8'hF8);
        acc(1'b1, 4'hB, 8'h07);
    endtask
    task t_dma;
        arm = 5'h11;
        ev[0] = 8'h08;
        ev[4] = 8'h08;
        @(negedge mclk_i);
        ev[0] = '0;
        ev[4] = '0;
        for (n = 0; n < 8 && ai[0]; n++) @(negedge mclk_i);
        if (n == 8) begin
            fails++;
            wrap_up();
        end
        repeat (3) @(negedge mclk_i);
        chk({3'h0, ai}, 8'h10);
        arm = 5'h00;
    endtask
    task t_standby;
        stby = 1'b1;
        repeat (2) @(negedge mclk_i);
        stby = 1'b0;
        chk({3'h0, wi | bi | ai}, 8'h00);
        acc(1'b0, 4'hC, 8'h00);
        chk(r, 8'hF8);
        acc(1'b0, 4'h4, 8'h00);
        chk(r, 8'hF8);
    endtask
    initial begin
        repeat (4) @(negedge mclk_i);
        rstn_n = 1'b1;
        repeat (3) @(negedge mclk_i);
        t_map();
        t_events();
        t_down();
        t_clear();
        t_mask();
        t_dma();
        t_standby();
        wrap_up();
    end
endmodule
